// [src/bsl_pkg.sv]
// Package of constants and types for the boot status indicator sequencer
package bsl_pkg;
    // Clock rate and pattern timing
    localparam int CLK_HZ = 40000000;
    localparam int POWERON_MS = 1000;
    localparam int POWERON_CYC = CLK_HZ / 1000 * POWERON_MS;
    localparam int FAST_MS = 100;
    localparam int SLOW_MS = 1000;
    localparam int BEAT_MS = 500;
    localparam int BEAT_ON_MS = 100;
    localparam int FAST_CYC = CLK_HZ / 1000 * FAST_MS;
    localparam int SLOW_CYC = CLK_HZ / 1000 * SLOW_MS;
    localparam int BEAT_CYC = CLK_HZ / 1000 * BEAT_MS;
    localparam int BEAT_ON_CYC = CLK_HZ / 1000 * BEAT_ON_MS;
    localparam int CNT_W = 32;

    // Indicator colours on the two-bit output
    typedef enum logic [1:0] {
        BSL_OFF = 2'h0,
        BSL_RED = 2'h1,
        BSL_GREEN = 2'h2,
        BSL_YELLOW = 2'h3
    } bsl_colour_t;

    // Boot phase as reported by firmware
    typedef enum logic [2:0] {
        BSL_PH_FLASH = 3'h0,
        BSL_PH_MEMCHK = 3'h1,
        BSL_PH_PANEL = 3'h2,
        BSL_PH_PREBOOT = 3'h3,
        BSL_PH_DISK = 3'h4,
        BSL_PH_FWBOOT = 3'h5,
        BSL_PH_OPER = 3'h6
    } bsl_phase_t;

    // Sequencer states
    typedef enum logic [2:0] {
        BSL_ST_POWERON = 3'h0,
        BSL_ST_RUN = 3'h1,
        BSL_ST_HALTRED = 3'h2,
        BSL_ST_DEAD = 3'h3,
        BSL_ST_SLEEP = 3'h4
    } bsl_state_t;
endpackage

// [src/bsl_blink_if.sv]
// Interface carrying the blink pattern phases to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface bsl_blink_if;
    logic fastOn;
    logic slowOn;
    logic beatOn;
    modport gen (output fastOn, output slowOn, output beatOn);
    modport use_ (input fastOn, input slowOn, input beatOn);
endinterface
`default_nettype wire

// [src/bsl_blink_gen.sv]
// Pattern generator for fast flash, slow blink and heartbeat
`timescale 1ns/1ps
`default_nettype none
module bsl_blink_gen
    import bsl_pkg::*;
#(
    parameter int FAST_P = FAST_CYC,
    parameter int SLOW_P = SLOW_CYC,
    parameter int BEAT_P = BEAT_CYC,
    parameter int BEAT_ON_P = BEAT_ON_CYC
) (
    input wire logic clk,
    input wire logic srst,
    bsl_blink_if.gen blink
);
    typedef struct packed {
        logic [CNT_W-1:0] fastCnt;
        logic [CNT_W-1:0] slowCnt;
        logic [CNT_W-1:0] beatCnt;
        logic fastOn;
        logic slowOn;
        logic beatOn;
    } bsl_gen_t;

    bsl_gen_t st_r;
    bsl_gen_t st_nxt;

    // Three free counters; fast and slow toggle their phase at half period
    always_comb begin
        st_nxt = st_r;
        st_nxt.fastCnt = st_r.fastCnt + 32'h1;
        st_nxt.slowCnt = st_r.slowCnt + 32'h1;
        st_nxt.beatCnt = st_r.beatCnt + 32'h1;
        if (st_r.fastCnt >= CNT_W'(FAST_P / 2 - 1)) begin
            st_nxt.fastCnt = '0;
            st_nxt.fastOn = ~st_r.fastOn;
        end
        if (st_r.slowCnt >= CNT_W'(SLOW_P / 2 - 1)) begin
            st_nxt.slowCnt = '0;
            st_nxt.slowOn = ~st_r.slowOn;
        end
        // Heartbeat is a short pulse each period, not a square wave
        if (st_r.beatCnt >= CNT_W'(BEAT_P - 1)) begin
            st_nxt.beatCnt = '0;
        end
        st_nxt.beatOn = (st_nxt.beatCnt < CNT_W'(BEAT_ON_P));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign blink.fastOn = st_r.fastOn;
    assign blink.slowOn = st_r.slowOn;
    assign blink.beatOn = st_r.beatOn;
endmodule
`default_nettype wire

// [src/bsl_sequencer.sv]
// Boot status indicator sequencer: boot phase and errors to colour pattern
//
// Notes on behaviour
// - After power-up show solid red at most one second, then advance.
// - Hardware discovery failure at power-on holds solid red, boot halted.
// - Flash boot shows green; corrupt or missing image gives red and halts.
// - Memory checks show green; self-check failure gives red and halts.
// - Panel link bring-up green; link failure flashes yellow, boot continues.
// - Preboot menu green; diagnostic failure gives red until power cycle.
// - Disk and firmware boot green; panel absent flashes yellow fast.
// - Operational state shows green heartbeat blink.
// - Panel link lost after operational gives yellow fast flash.
// - Freeze or fatal firmware error turns indicator off; a red halt already reached stays red.
// - Sleep or approaching sleep blinks green slowly; wake replays boot progression.
`timescale 1ns/1ps
`default_nettype none
module bsl_sequencer
    import bsl_pkg::*;
#(
    parameter int POWERON_P = POWERON_CYC,
    parameter int FAST_P = FAST_CYC,
    parameter int SLOW_P = SLOW_CYC,
    parameter int BEAT_P = BEAT_CYC,
    parameter int BEAT_ON_P = BEAT_ON_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] bootPhase,
    input wire logic hwDiscoverFail,
    input wire logic flashFail,
    input wire logic memCheckFail,
    input wire logic diagFail,
    input wire logic panelLinkOk,
    input wire logic fatalError,
    input wire logic sleepReq,
    output logic [1:0] ledColour,
    output logic bootHalted
);
    bsl_blink_if blink ();

    bsl_blink_gen #(
        .FAST_P(FAST_P),
        .SLOW_P(SLOW_P),
        .BEAT_P(BEAT_P),
        .BEAT_ON_P(BEAT_ON_P)
    ) u_gen (
        .clk(clk),
        .srst(srst),
        .blink(blink)
    );

    typedef struct packed {
        logic [2:0] phaseS1;
        logic [2:0] phaseS2;
        logic [2:0] phaseS3;
        logic [2:0] phaseAcc;
        logic [6:0] failS1;
        logic [6:0] failS2;
        bsl_state_t state;
        logic [CNT_W-1:0] cnt;
        bsl_colour_t colour;
        logic halted;
    } bsl_seq_t;

    bsl_seq_t st_r;
    bsl_seq_t st_nxt;

    // Decoded synchronised inputs
    bsl_phase_t phase;
    logic hwFailS;
    logic flashFailS;
    logic memFailS;
    logic diagFailS;
    logic linkOkS;
    logic fatalS;
    logic sleepS;

    // Green when the panel link is up, yellow fast flash when it is not
    function automatic bsl_colour_t link_colour(input logic ok, input logic flash);
        bsl_colour_t c;
        c = BSL_OFF;
        if (ok) begin
            c = BSL_GREEN;
        end else if (flash) begin
            c = BSL_YELLOW;
        end
        return c;
    endfunction

    always_comb begin
        // Phase word may be caught mid-change; take it once two samples agree
        phase = bsl_phase_t'(st_r.phaseAcc);
        if (st_r.phaseS2 == st_r.phaseS3) begin
            phase = bsl_phase_t'(st_r.phaseS2);
        end
        hwFailS = st_r.failS2[0];
        flashFailS = st_r.failS2[1];
        memFailS = st_r.failS2[2];
        diagFailS = st_r.failS2[3];
        linkOkS = st_r.failS2[4];
        fatalS = st_r.failS2[5];
        sleepS = st_r.failS2[6];
    end

    // Inputs come from firmware-driven pins; two stages before use
    always_comb begin
        st_nxt = st_r;
        st_nxt.phaseS1 = bootPhase;
        st_nxt.phaseS2 = st_r.phaseS1;
        st_nxt.phaseS3 = st_r.phaseS2;
        st_nxt.phaseAcc = phase; // Last agreed phase, held across a change
        st_nxt.failS1 = {sleepReq, fatalError, panelLinkOk, diagFail,
                         memCheckFail, flashFail, hwDiscoverFail};
        st_nxt.failS2 = st_r.failS1;
        st_nxt.halted = 1'b0;
        st_nxt.colour = BSL_OFF;
        unique case (st_r.state)
            BSL_ST_POWERON: begin
                // Red at most the power-on time, then hand over to phases
                st_nxt.colour = BSL_RED;
                st_nxt.cnt = st_r.cnt + 32'h1;
                if (hwFailS) begin
                    st_nxt.state = BSL_ST_HALTRED;
                    st_nxt.halted = 1'b1;
                end else if (st_r.cnt >= CNT_W'(POWERON_P - 1)) begin
                    st_nxt.state = BSL_ST_RUN;
                    st_nxt.colour = BSL_GREEN;
                    st_nxt.cnt = '0;
                end
            end
            BSL_ST_RUN: begin
                st_nxt.colour = BSL_GREEN;
                unique case (phase)
                    BSL_PH_FLASH: begin
                        if (flashFailS) begin
                            st_nxt.state = BSL_ST_HALTRED;
                        end
                    end
                    BSL_PH_MEMCHK: begin
                        if (memFailS) begin
                            st_nxt.state = BSL_ST_HALTRED;
                        end
                    end
                    BSL_PH_PANEL: begin
                        // Boot keeps going; only the colour reports the fault
                        st_nxt.colour = link_colour(linkOkS, blink.fastOn);
                    end
                    BSL_PH_PREBOOT: begin
                        if (diagFailS) begin
                            st_nxt.state = BSL_ST_HALTRED;
                        end
                    end
                    BSL_PH_DISK, BSL_PH_FWBOOT: begin
                        st_nxt.colour = link_colour(linkOkS, blink.fastOn);
                    end
                    BSL_PH_OPER: begin
                        // Heartbeat while linked, fast yellow once link lost
                        st_nxt.colour = linkOkS
                            ? (blink.beatOn ? BSL_GREEN : BSL_OFF)
                            : link_colour(1'b0, blink.fastOn);
                        if (sleepS) begin
                            st_nxt.state = BSL_ST_SLEEP;
                        end
                    end
                    default: begin
                        st_nxt.colour = BSL_GREEN;
                    end
                endcase
                if (st_nxt.state == BSL_ST_HALTRED) begin
                    st_nxt.colour = BSL_RED;
                    st_nxt.halted = 1'b1;
                end
            end
            BSL_ST_HALTRED: begin
                // Only reset (power cycle) leaves this state
                st_nxt.colour = BSL_RED;
                st_nxt.halted = 1'b1;
            end
            BSL_ST_DEAD: begin
                st_nxt.colour = BSL_OFF;
                st_nxt.halted = 1'b1;
            end
            BSL_ST_SLEEP: begin
                st_nxt.colour = blink.slowOn ? BSL_GREEN : BSL_OFF;
                if (!sleepS) begin
                    // Wake replays the whole progression from power-on
                    st_nxt.state = BSL_ST_POWERON;
                    st_nxt.cnt = '0;
                    st_nxt.colour = BSL_RED;
                end
            end
            default: begin
                st_nxt.state = BSL_ST_POWERON;
                st_nxt.cnt = '0;
            end
        endcase
        // Approaching sleep in any run phase before operational also blinks slowly
        if (st_r.state == BSL_ST_RUN && sleepS && phase != BSL_PH_OPER
                && st_nxt.state == BSL_ST_RUN) begin
            st_nxt.colour = blink.slowOn ? BSL_GREEN : BSL_OFF;
        end
        // Fatal error beats every other indication except the red halt
        if (fatalS && st_r.state != BSL_ST_HALTRED) begin
            st_nxt.state = BSL_ST_DEAD;
            st_nxt.colour = BSL_OFF;
            st_nxt.halted = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.state <= BSL_ST_POWERON;
            st_r.colour <= BSL_RED;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ledColour = st_r.colour;
    assign bootHalted = st_r.halted;
endmodule
`default_nettype wire

// [dv/bsl_seq_checker.sv]
// Port checker for the boot status indicator sequencer
`timescale 1ns/1ps
`default_nettype none
module bsl_seq_checker
    import bsl_pkg::*;
#(
    parameter int POWERON_P = 20,
    parameter int FAST_P = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic panelLinkOk,
    input wire logic fatalError,
    input wire logic [1:0] ledColour,
    input wire logic bootHalted
);
    int redCnt_r = 0;
    int yelCnt_r = 0;
    // Run lengths; slack on red allows for input sync delay
    always_ff @(posedge clk) begin
        redCnt_r <= (!srst && ledColour == BSL_RED && !bootHalted) ? redCnt_r + 1 : 0;
        yelCnt_r <= (ledColour == BSL_YELLOW) ? yelCnt_r + 1 : 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    rst_red_a: assert property (disable iff (1'h0)
        srst |=> ledColour == BSL_RED && !bootHalted) else $error("no red after reset");
    red_run_a: assert property (redCnt_r <= POWERON_P + 8)
        else $error("power-on red too long");
    halt_red_a: assert property (bootHalted && ledColour == BSL_RED |=>
        bootHalted && ledColour == BSL_RED) else $error("red halt left");
    off_hold_a: assert property (bootHalted && ledColour == BSL_OFF |=>
        bootHalted && ledColour == BSL_OFF) else $error("fatal off left");
    halt_col_a: assert property (bootHalted |-> ledColour inside {BSL_RED, BSL_OFF})
        else $error("halted with colour");
    fatal_off_a: assert property (fatalError [*4] |=> ledColour == BSL_OFF ||
        bootHalted && ledColour == BSL_RED) else $error("fatal not off");
    link_ok_a: assert property (panelLinkOk [*4] |=> ledColour != BSL_YELLOW)
        else $error("yellow with link up");
    yel_run_a: assert property (yelCnt_r <= FAST_P / 2)
        else $error("yellow run too long");
    cover property ($rose(bootHalted));
    cover property (ledColour == BSL_YELLOW);
    cover property (bootHalted && ledColour == BSL_OFF);
endmodule
`default_nettype wire

// [dv/bsl_fw_model.sv]
// Boot firmware model reporting one more boot phase per step
`timescale 1ns/1ps
`default_nettype none
module bsl_fw_model
    import bsl_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic step,
    output logic [2:0] bootPhase
);
    // Phases only climb; operational is held until reset
    always_ff @(posedge clk) begin
        if (srst) begin
            bootPhase <= BSL_PH_FLASH;
        end else if (step && bootPhase != BSL_PH_OPER) begin
            bootPhase <= bootPhase + 3'h1;
        end
    end
endmodule
`default_nettype wire

// [dv/boot_status_led_sequencer_test.sv]
// Testbench for the boot status indicator sequencer
`timescale 1ns/1ps
`default_nettype none
module boot_status_led_sequencer_test;
    import bsl_pkg::*;
    typedef struct {int n; logic [3:0] mask; int cnt; logic halt;} bsl_note_t;
    logic clk = 1'h0, srst = 1'h1, step = 1'h0, hwFail = 1'h0, linkOk = 1'h1;
    logic fatal = 1'h0, sleep = 1'h0, noise = 1'h0, flFail = 1'h0, memFail = 1'h0, dgFail = 1'h0;
    logic [2:0] failSet = 3'h0;
    logic [2:0] phase;
    logic [1:0] colour;
    logic halted;
    int badCount = 0, numChecks = 0, seed = 57100;
    int ph[4] = '{0, 0, 1, 3};
    bsl_note_t q[$];
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Stray failures are random only where their phase ignores them
    always @(posedge clk) begin
        {flFail, memFail, dgFail} <= noise ? 3'($random(seed)) : failSet;
    end
    bsl_fw_model fw_u (.clk(clk), .srst(srst), .step(step), .bootPhase(phase));
    bsl_sequencer #(.POWERON_P(20), .FAST_P(8), .SLOW_P(32), .BEAT_P(16), .BEAT_ON_P(2)) dut_u (
        .clk(clk), .srst(srst), .bootPhase(phase), .hwDiscoverFail(hwFail), .flashFail(flFail),
        .memCheckFail(memFail), .diagFail(dgFail), .panelLinkOk(linkOk), .fatalError(fatal),
        .sleepReq(sleep), .ledColour(colour), .bootHalted(halted));
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic printVerdict();
        if (badCount == 0 && numChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic restart(int n);
        srst <= 1'h1;
        cyc(n);
        srst <= 1'h0;
    endtask
    task automatic to_phase(int p);
        while (phase !== 3'(p)) begin
            step <= 1'h1;
            cyc(1);
            step <= 1'h0;
            cyc(1);
        end
    endtask
    // Note a window: colours seen, cycles lit, halt flag at its end
    task automatic note_win(int n, logic [3:0] mask, int cnt, logic halt);
        q.push_back('{n, mask, cnt, halt});
        wait (q.size() == 0);
        // Back onto the rising edge before the next stimulus
        @(posedge clk);
    endtask
    // Monitor skips the input latency, samples at falling edges, judges oldest note
    initial begin
        bsl_note_t nt;
        logic [3:0] seen;
        int on;
        forever begin
            wait (q.size() > 0);
            nt = q[0];
            seen = 4'h0;
            on = 0;
            repeat (4) @(posedge clk);
            repeat (nt.n) begin
                @(negedge clk);
                seen[colour] = 1'h1;
                on += (colour != BSL_OFF);
            end
            check("colours", {4'h0, seen}, {4'h0, nt.mask});
            check("lit cycles", 8'(on), 8'(nt.cnt));
            check("halted", {7'h0, halted}, {7'h0, nt.halt});
            void'(q.pop_front());
        end
    end
    initial begin
        restart(20);
        cyc(5);
        note_win(4, 4'h2, 4, 1'h0);
        cyc(20);
        note_win(8, 4'h4, 8, 1'h0);
        // Each failure halts red, and later phases do not lift it
        foreach (ph[i]) begin
            restart(2);
            hwFail <= (i == 0);
            cyc(30);
            to_phase(ph[i]);
            failSet <= {i == 1, i == 2, i == 3};
            cyc(3);
            failSet <= 3'h0;
            hwFail <= 1'h0;
            to_phase(6);
            note_win(8, 4'h2, 8, 1'h1);
        end
        restart(2);
        cyc(30);
        for (int p = 2; p < 6; p++) begin
            to_phase(p);
            noise <= (p != 3);
            note_win(16, 4'h4, 16, 1'h0);
            noise <= 1'h0;
            linkOk <= (p == 3);
            note_win(16, (p == 3) ? 4'h4 : 4'h9, (p == 3) ? 16 : 8, 1'h0);
            linkOk <= 1'h1;
            cyc(2);
        end
        // Approaching sleep before operational blinks slowly, boot state kept
        sleep <= 1'h1;
        note_win(32, 4'h5, 16, 1'h0);
        sleep <= 1'h0;
        to_phase(6);
        note_win(32, 4'h5, 4, 1'h0);
        linkOk <= 1'h0;
        note_win(16, 4'h9, 8, 1'h0);
        linkOk <= 1'h1;
        sleep <= 1'h1;
        note_win(32, 4'h5, 16, 1'h0);
        sleep <= 1'h0;
        note_win(8, 4'h2, 8, 1'h0);
        cyc(30);
        note_win(32, 4'h5, 4, 1'h0);
        fatal <= 1'h1;
        note_win(8, 4'h1, 0, 1'h1);
        fatal <= 1'h0;
        note_win(8, 4'h1, 0, 1'h1);
        printVerdict();
    end
    // Whole run is under 1500 cycles
    initial begin
        #(25 * 5000);
        badCount++;
        printVerdict();
    end
endmodule
bind bsl_sequencer bsl_seq_checker #(.POWERON_P(POWERON_P), .FAST_P(FAST_P)) chk_u (
    .clk(clk), .srst(srst), .panelLinkOk(panelLinkOk), .fatalError(fatalError),
    .ledColour(ledColour), .bootHalted(bootHalted));
`default_nettype wire
